/* File: verilog/hdlc_status_consts.svh */
// Offsets, field positions, reset values and counts for the HDLC status block
`ifndef HDLC_STATUS_CONSTS_SVH
`define HDLC_STATUS_CONSTS_SVH
`define OFF_RX_BYTES_AVAIL   12'h0b4
`define OFF_RX_DATA          12'h0b8
`define OFF_RX_RT_STATUS     12'h0bc
`define OFF_RX_LATCHED       12'h094
`define OFF_RX_MASK          12'h0a4
`define OFF_TX_LATCHED       12'h190
`define OFF_TX_MASK          12'h1a0
`define OFF_TX_SPACE         12'h1b0
`define OFF_TX_DATA          12'h1b4
`define OFF_WATERMARK        12'h1b8
`define BIT_RX_HWM           1
`define BIT_RX_PKT_END       0
`define BIT_RX_OVR           5
`define BIT_RX_PKT_START     1
`define BIT_TX_LWM           0
`define BIT_TX_UNDER         1
`define BIT_MORE_FLAG        7
`define RST_MASK             8'h00
`define RST_HIGH_WM          7'h30
`define RST_LOW_WM           7'h10
`define FIFO_DEPTH_DEF       64
`endif

/* File: verilog/hdlc_status_pkg.sv */
// Types shared by the HDLC status block
package hdlc_status_pkg;
	typedef enum logic [1:0] {SEG_FIRST, SEG_CONT, SEG_LAST, SEG_WHOLE} segment_t;
	typedef enum {APB_IDLE, APB_ACCESS} apb_state_t;
endpackage

/* File: verilog/hdlc_byte_mem.sv */
// Small byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module hdlc_byte_mem #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// Clock
	input  wire logic          core_clk,
	// Write port
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [8:0]    wrData,
	// Read port
	input  wire logic [AW-1:0] rdAddr,
	output var  logic [8:0]    rdData
);
	logic [8:0] mem [DEPTH];

	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule
`default_nettype wire

/* File: verilog/skid_buffer2.sv */
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module skid_buffer2 #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         arst_n,
	// Fill side
	input  wire logic         inValid,
	output var  logic         inReady,
	input  wire logic [W-1:0] inData,
	// Drain side
	output var  logic         outValid,
	input  wire logic         outReady,
	output var  logic [W-1:0] outData
);
	logic [W-1:0] skid_reg;
	logic         skidValid_reg;
	logic         outFree;

	// Skid slot catches a word offered while the output stalls
	assign inReady = !skidValid_reg;
	assign outFree = outReady || !outValid;

	// Output stage is a register so the drain side sees flop outputs
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			outValid      <= 1'b0;
			outData       <= '0;
			skidValid_reg <= 1'b0;
		end else if (outFree) begin
			if (skidValid_reg) begin
				outValid      <= 1'b1;
				outData       <= skid_reg;
				skidValid_reg <= 1'b0;
			end else begin
				outValid <= inValid;
				if (inValid) begin
					outData <= inData;
				end
			end
		end else if (inValid && inReady) begin
			skidValid_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (inValid && inReady && !outFree) begin
			skid_reg <= inData;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/hdlc_fifo_host_status.sv */
// HDLC FIFO counts, status, masks and interrupt for one framer
//
// Decided for this implementation: the register offsets and register access over APB.
`include "hdlc_status_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hdlc_fifo_host_status
	import hdlc_status_pkg::*;
#(
	parameter int DEPTH = `FIFO_DEPTH_DEF,
	parameter int AW    = 6
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Receive bytes from the framing engine; pktEnd marks last byte
	input  wire logic        rxValid,
	input  wire logic [7:0]  rxData,
	input  wire logic        rxPktEnd,
	input  wire logic        rxPktStart,
	// Transmit bytes toward the framing engine
	output var  logic        txValid,
	input  wire logic        txReady,
	output var  logic [7:0]  txData,
	// Interrupt
	output var  logic        interrupt_out_n
);
	localparam logic [7:0] DEPTH8 = 8'(DEPTH);

	// Receive FIFO
	logic [AW-1:0] rxWr_reg, rxRd_reg;
	logic [7:0]    rxFill_reg;
	logic [7:0]    rxAvail_reg;
	logic          rxOpen_reg;
	logic [8:0]    rxMemOut;
	logic          rxWrEn;
	logic          rxPop;
	logic          rxOverrun;
	// Transmit FIFO
	logic [AW-1:0] txWr_reg, txRd_reg;
	logic [7:0]    txFill_reg;
	logic [8:0]    txMemOut;
	logic          txPush;
	logic          txMemValid_reg;
	logic          bufInReady;
	logic          txTake;
	logic          txUnder;
	// Registers
	logic [7:0]    rxLatched_reg, txLatched_reg;
	logic [7:0]    rxMask_reg, txMask_reg;
	logic [6:0]    highWm_reg, lowWm_reg;
	logic [7:0]    txSpaceHold_reg;
	logic [7:0]    rxRealtime;
	logic [7:0]    txRealtime;
	logic [7:0]    rxEvents, txEvents;
	apb_state_t    apb_reg;
	logic          wrStrobe, rdStrobe;
	logic [7:0]    rxCause_reg, txCause_reg;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return hit(a, `OFF_RX_BYTES_AVAIL) || hit(a, `OFF_RX_DATA) ||
			hit(a, `OFF_RX_RT_STATUS) || hit(a, `OFF_RX_LATCHED) ||
			hit(a, `OFF_RX_MASK) || hit(a, `OFF_TX_LATCHED) ||
			hit(a, `OFF_TX_MASK) || hit(a, `OFF_TX_SPACE) ||
			hit(a, `OFF_TX_DATA) || hit(a, `OFF_WATERMARK);
	endfunction

	assign wrStrobe = (apb_reg == APB_ACCESS) && psel && penable && pwrite;
	assign rdStrobe = (apb_reg == APB_ACCESS) && psel && penable && !pwrite;

	// APB two-phase, no wait states
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			apb_reg <= APB_IDLE;
		end else begin
			case (apb_reg)
				APB_IDLE:   apb_reg <= (psel && !penable) ? APB_ACCESS : APB_IDLE;
				APB_ACCESS: apb_reg <= APB_IDLE;
				default:    apb_reg <= APB_IDLE;
			endcase
		end
	end

	// Overrun when full and a byte arrives
	assign rxOverrun = rxValid && (rxFill_reg == DEPTH8);
	assign rxWrEn    = rxValid && !rxOverrun;
	assign rxPop     = rdStrobe && hit(paddr, `OFF_RX_DATA) && (rxFill_reg != 8'd0);

	hdlc_byte_mem #(.DEPTH(DEPTH), .AW(AW)) u_rxMem (
		.core_clk (core_clk),
		.wrEn     (rxWrEn),
		.wrAddr   (rxWr_reg),
		.wrData   ({rxPktEnd, rxData}),
		.rdAddr   (rxPop ? rxRd_reg + AW'(1) : rxRd_reg),
		.rdData   (rxMemOut)
	);

	// Receive pointers, fill and segment-aware count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxWr_reg    <= '0;
			rxRd_reg    <= '0;
			rxFill_reg  <= 8'd0;
			rxAvail_reg <= 8'd0;
			rxOpen_reg  <= 1'b0;
		end else if (rxOverrun) begin
			rxWr_reg    <= '0;
			rxRd_reg    <= '0;
			rxFill_reg  <= 8'd0;
			rxAvail_reg <= 8'd0;
			rxOpen_reg  <= 1'b0;
		end else begin
			if (rxWrEn) begin
				rxWr_reg <= rxWr_reg + AW'(1);
			end
			if (rxPop) begin
				rxRd_reg <= rxRd_reg + AW'(1);
			end
			rxFill_reg <= rxFill_reg + {7'd0, rxWrEn} - {7'd0, rxPop};
			if (rxPop && rxMemOut[8]) begin
				rxAvail_reg <= rxWrEn ? 8'd1 : 8'd0;
			end else begin
				rxAvail_reg <= rxAvail_reg + {7'd0, rxWrEn} - {7'd0, rxPop};
			end
			if (rxWrEn) begin
				rxOpen_reg <= !rxPktEnd;
			end
		end
	end

	segment_t rxSeg;
	always_comb begin
		rxSeg = SEG_WHOLE;
		if (rxOpen_reg && rxAvail_reg == rxFill_reg) begin
			rxSeg = SEG_CONT;
		end else if (rxOpen_reg) begin
			rxSeg = SEG_FIRST;
		end else begin
			rxSeg = SEG_LAST;
		end
	end

	always_comb begin
		rxRealtime = 8'h00;
		rxRealtime[`BIT_RX_HWM] = rxFill_reg > {1'b0, highWm_reg};
		rxRealtime[`BIT_RX_PKT_END] = !rxOpen_reg && (rxAvail_reg != 8'd0);
		txRealtime = 8'h00;
		txRealtime[`BIT_TX_LWM] = txFill_reg < {1'b0, lowWm_reg};
	end

	// Transmit FIFO
	assign txPush  = wrStrobe && hit(paddr, `OFF_TX_DATA) && (txFill_reg != DEPTH8);
	assign txTake  = txMemValid_reg && bufInReady;
	assign txUnder = txReady && !txValid;

	hdlc_byte_mem #(.DEPTH(DEPTH), .AW(AW)) u_txMem (
		.core_clk (core_clk),
		.wrEn     (txPush),
		.wrAddr   (txWr_reg),
		.wrData   ({1'b0, pwdata[7:0]}),
		// Re-read the held byte while the buffer stalls
		.rdAddr   (txMemValid_reg ? txRd_reg - AW'(1) : txRd_reg),
		.rdData   (txMemOut)
	);

	skid_buffer2 #(.W(8)) u_txBuf (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.inValid  (txMemValid_reg),
		.inReady  (bufInReady),
		.inData   (txMemOut[7:0]),
		.outValid (txValid),
		.outReady (txReady),
		.outData  (txData)
	);

	// Transmit pointers; memory read word valid one cycle after address
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txWr_reg       <= '0;
			txRd_reg       <= '0;
			txFill_reg     <= 8'd0;
			txMemValid_reg <= 1'b0;
		end else begin
			if (txPush) begin
				txWr_reg <= txWr_reg + AW'(1);
			end
			if (txTake) begin
				txMemValid_reg <= 1'b0;
			end else if (!txMemValid_reg && txFill_reg != 8'd0 && !txPush) begin
				txMemValid_reg <= 1'b1;
				txRd_reg       <= txRd_reg + AW'(1);
			end
			// Held byte keeps its slot until the buffer takes it
			txFill_reg <= txFill_reg + {7'd0, txPush} - {7'd0, txTake};
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txSpaceHold_reg <= DEPTH8;
		end else if (!(psel && apb_reg == APB_ACCESS)) begin
			txSpaceHold_reg <= DEPTH8 - txFill_reg;
		end
	end

	always_comb begin
		rxEvents = 8'h00;
		rxEvents[`BIT_RX_OVR]       = rxOverrun;
		rxEvents[`BIT_RX_PKT_START] = rxWrEn && rxPktStart;
		rxEvents[`BIT_RX_PKT_END]   = rxWrEn && rxPktEnd;
		txEvents = 8'h00;
		txEvents[`BIT_TX_UNDER]     = txUnder;
		txEvents[`BIT_TX_LWM]       = txPush == 1'b0 && txFill_reg == {1'b0, lowWm_reg};
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxLatched_reg <= 8'h00;
			txLatched_reg <= 8'h00;
		end else begin
			rxLatched_reg <= rxEvents | (rxLatched_reg &
				~((wrStrobe && hit(paddr, `OFF_RX_LATCHED)) ? pwdata[7:0] : 8'h00));
			txLatched_reg <= txEvents | (txLatched_reg &
				~((wrStrobe && hit(paddr, `OFF_TX_LATCHED)) ? pwdata[7:0] : 8'h00));
		end
	end

	// Masks and watermarks
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxMask_reg <= `RST_MASK;
			txMask_reg <= `RST_MASK;
			highWm_reg <= `RST_HIGH_WM;
			lowWm_reg  <= `RST_LOW_WM;
		end else if (wrStrobe) begin
			if (hit(paddr, `OFF_RX_MASK)) begin
				rxMask_reg <= pwdata[7:0];
			end
			if (hit(paddr, `OFF_TX_MASK)) begin
				txMask_reg <= pwdata[7:0];
			end
			if (hit(paddr, `OFF_WATERMARK)) begin
				highWm_reg <= pwdata[6:0];
				lowWm_reg  <= pwdata[14:8];
			end
		end
	end

	// Cause bits cleared by reading the latched register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxCause_reg <= 8'h00;
			txCause_reg <= 8'h00;
		end else begin
			rxCause_reg <= (rxEvents & rxMask_reg) | (rxCause_reg & rxLatched_reg &
				rxMask_reg & ~((rdStrobe && hit(paddr, `OFF_RX_LATCHED)) ? 8'hff : 8'h00));
			txCause_reg <= (txEvents & txMask_reg) | (txCause_reg & txLatched_reg &
				txMask_reg & ~((rdStrobe && hit(paddr, `OFF_TX_LATCHED)) ? 8'hff : 8'h00));
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			interrupt_out_n <= 1'b1;
		end else begin
			interrupt_out_n <= !(|{rxCause_reg, txCause_reg});
		end
	end

	// Read data, registered; answer in access phase
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped(paddr);
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`OFF_RX_BYTES_AVAIL: prdata <= {24'h0,
						(rxSeg == SEG_FIRST || rxSeg == SEG_CONT), rxAvail_reg[6:0]};
					`OFF_RX_DATA:        prdata <= {24'h0, rxMemOut[7:0]};
					`OFF_RX_RT_STATUS:   prdata <= {24'h0, rxRealtime};
					`OFF_RX_LATCHED:     prdata <= {24'h0, rxLatched_reg};
					`OFF_RX_MASK:        prdata <= {24'h0, rxMask_reg};
					`OFF_TX_LATCHED:     prdata <= {24'h0, txLatched_reg | txRealtime};
					`OFF_TX_MASK:        prdata <= {24'h0, txMask_reg};
					`OFF_TX_SPACE:       prdata <= {24'h0, txSpaceHold_reg};
					`OFF_WATERMARK:      prdata <= {17'h0, lowWm_reg, 1'b0, highWm_reg};
					default:             prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/hdlc_fifo_host_status_assertions.sv */
// Port checker for the HDLC status block
`include "hdlc_status_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hdlc_fifo_host_status_assertions (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        arst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Streams
	input wire logic        rxValid,
	input wire logic [7:0]  rxData,
	input wire logic        rxPktEnd,
	input wire logic        rxPktStart,
	input wire logic        txValid,
	input wire logic        txReady,
	input wire logic [7:0]  txData,
	// Interrupt
	input wire logic        interrupt_out_n
);
	logic rdDone;
	logic hostTouch;
	assign rdDone = pready && !pwrite;
	assign hostTouch = pready && (paddr == `OFF_RX_LATCHED || paddr == `OFF_TX_LATCHED
		|| paddr == `OFF_RX_MASK || paddr == `OFF_TX_MASK);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_setup; psel && !penable; endsequence
	sequence s_touched; $past(hostTouch, 1) || $past(hostTouch, 2) || $past(hostTouch, 3);
	endsequence
	property p_answer; s_setup |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("no answer in access");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_avail; rdDone && paddr == `OFF_RX_BYTES_AVAIL
		|-> prdata[6:0] <= 7'h40 && prdata[31:8] == 24'h0; endproperty
	a_avail: assert property (p_avail) else $error("count out of range");
	property p_rt; rdDone && paddr == `OFF_RX_RT_STATUS |-> prdata[31:2] == 30'h0; endproperty
	a_rt: assert property (p_rt) else $error("stray realtime bits");
	property p_lat; rdDone && paddr == `OFF_RX_LATCHED |-> (prdata & ~32'h23) == 32'h0;
	endproperty
	a_lat: assert property (p_lat) else $error("stray latched bits");
	property p_release; $rose(interrupt_out_n) |-> s_touched; endproperty
	a_release: assert property (p_release) else $error("interrupt released alone");
	property p_txHold; txValid && !txReady |=> txValid && $stable(txData); endproperty
	a_txHold: assert property (p_txHold) else $error("stalled byte lost");
endmodule
bind hdlc_fifo_host_status hdlc_fifo_host_status_assertions i_chk (.core_clk(core_clk),
	.arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rxValid(rxValid), .rxData(rxData), .rxPktEnd(rxPktEnd), .rxPktStart(rxPktStart),
	.txValid(txValid), .txReady(txReady), .txData(txData),
	.interrupt_out_n(interrupt_out_n));
`default_nettype wire

/* File: tb/hdlc_engine_model.sv */
// Framing engine stand-in: byte source and stalling byte sink
`timescale 1ns/1ps
`default_nettype none
module hdlc_engine_model (
	// Clock
	input  wire logic       core_clk,
	// Receive byte source
	output var  logic       rxValid,
	output var  logic [7:0] rxData,
	output var  logic       rxPktEnd,
	output var  logic       rxPktStart,
	// Transmit byte sink
	input  wire logic       txValid,
	input  wire logic [7:0] txData,
	output var  logic       txReady,
	input  wire logic       stall
);
	logic [7:0] got[$];
	initial begin
		rxValid = 1'b0;
		rxData = 8'h5a;
		rxPktEnd = 1'b0;
		rxPktStart = 1'b0;
		txReady = 1'b0;
	end
	// One byte pulse; idle data inverted so nothing stale shows
	task automatic sendByte(input logic [7:0] d, input logic s, input logic e);
		@(posedge core_clk);
		rxValid <= 1'b1;
		rxData <= d;
		rxPktStart <= s;
		rxPktEnd <= e;
		@(posedge core_clk);
		rxValid <= 1'b0;
		rxData <= ~d;
		rxPktStart <= 1'b0;
		rxPktEnd <= 1'b0;
	endtask
	always @(posedge core_clk) begin
		txReady <= !stall;
		if (txValid && txReady)
			got.push_back(txData);
	end
endmodule
`default_nettype wire

/* File: tb/tb_hdlc_fifo_host_status.sv */
// Self-checking bench for the HDLC status block
`include "hdlc_status_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_hdlc_fifo_host_status;
	logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, stall, errSeen;
	logic        rxValid, rxPktEnd, rxPktStart, txValid, txReady, interrupt_out_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdData;
	logic [7:0]  rxData, txData;
	int          badCount, testsRun;
	hdlc_fifo_host_status i_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxData(rxData),
		.rxPktEnd(rxPktEnd), .rxPktStart(rxPktStart), .txValid(txValid), .txReady(txReady),
		.txData(txData), .interrupt_out_n(interrupt_out_n));
	hdlc_engine_model i_eng (.core_clk(core_clk), .rxValid(rxValid), .rxData(rxData),
		.rxPktEnd(rxPktEnd), .rxPktStart(rxPktStart), .txValid(txValid), .txData(txData),
		.txReady(txReady), .stall(stall));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		// pready ends this wait; if it never comes, only the watchdog does
		while (pready !== 1'b1)
			@(posedge core_clk);
		rdData = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdData & m, e);
	endtask
	task automatic summarize();
		$display("tests %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#1_000_000;
		badCount++;
		summarize();
	end
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		stall = 1'b0;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rdChk(`OFF_RX_MASK, 32'hff, 32'h0);
		rdChk(`OFF_WATERMARK, 32'h7f7f, 32'h1030);
		rdChk(12'h000, 32'hffffffff, 32'h0);
		chk(32'(errSeen), 32'h1);
		$display("test reset values done");
		for (int i = 1; i <= 3; i++)
			i_eng.sendByte(8'(17 * i), i == 1, i == 3);
		repeat (4) @(posedge core_clk);
		rdChk(`OFF_RX_BYTES_AVAIL, 32'hff, 32'h03);
		rdChk(`OFF_RX_LATCHED, 32'h23, 32'h03);
		for (int i = 1; i <= 3; i++)
			rdChk(`OFF_RX_DATA, 32'hff, 32'(8'(17 * i)));
		i_eng.sendByte(8'h44, 1'b1, 1'b0);
		i_eng.sendByte(8'h55, 1'b0, 1'b0);
		repeat (4) @(posedge core_clk);
		rdChk(`OFF_RX_BYTES_AVAIL, 32'hff, 32'h82);
		apb(1'b0, `OFF_RX_DATA, 32'h0);
		apb(1'b0, `OFF_RX_DATA, 32'h0);
		i_eng.sendByte(8'h66, 1'b0, 1'b1);
		repeat (4) @(posedge core_clk);
		rdChk(`OFF_RX_BYTES_AVAIL, 32'hff, 32'h01);
		rdChk(`OFF_RX_DATA, 32'hff, 32'h66);
		$display("test receive counts done");
		apb(1'b1, `OFF_RX_LATCHED, 32'h01);
		rdChk(`OFF_RX_LATCHED, 32'h23, 32'h02);
		apb(1'b1, `OFF_RX_LATCHED, 32'h02);
		rdChk(`OFF_RX_LATCHED, 32'h23, 32'h00);
		$display("test latched clear done");
		apb(1'b1, `OFF_RX_MASK, 32'h01);
		i_eng.sendByte(8'h77, 1'b1, 1'b0);
		repeat (4) @(posedge core_clk);
		chk(32'(interrupt_out_n), 32'h1);
		i_eng.sendByte(8'h78, 1'b0, 1'b1);
		repeat (4) @(posedge core_clk);
		chk(32'(interrupt_out_n), 32'h0);
		rdChk(`OFF_RX_LATCHED, 32'h01, 32'h01);
		repeat (2) @(posedge core_clk);
		chk(32'(interrupt_out_n), 32'h1);
		apb(1'b1, `OFF_RX_LATCHED, 32'h03);
		rdChk(`OFF_RX_LATCHED, 32'h03, 32'h00);
		repeat (4) @(posedge core_clk);
		chk(32'(interrupt_out_n), 32'h1);
		apb(1'b0, `OFF_RX_DATA, 32'h0);
		apb(1'b0, `OFF_RX_DATA, 32'h0);
		$display("test interrupt done");
		apb(1'b1, `OFF_WATERMARK, 32'h1004);
		for (int i = 0; i < 5; i++)
			i_eng.sendByte(8'(i), i == 0, 1'b0);
		repeat (4) @(posedge core_clk);
		rdChk(`OFF_RX_RT_STATUS, 32'h02, 32'h02);
		apb(1'b1, `OFF_RX_RT_STATUS, 32'hff);
		rdChk(`OFF_RX_RT_STATUS, 32'h02, 32'h02);
		for (int i = 5; i < 65; i++)
			i_eng.sendByte(8'(i), 1'b0, 1'b0);
		repeat (4) @(posedge core_clk);
		rdChk(`OFF_RX_LATCHED, 32'h20, 32'h20);
		rdChk(`OFF_RX_BYTES_AVAIL, 32'h7f, 32'h00);
		rdChk(`OFF_RX_RT_STATUS, 32'h02, 32'h00);
		$display("test watermark and overrun done");
		rdChk(`OFF_TX_SPACE, 32'hff, 32'h40);
		stall <= 1'b1;
		for (int i = 0; i < 5; i++)
			apb(1'b1, `OFF_TX_DATA, 32'(8'ha0 + 8'(i)));
		repeat (10) @(posedge core_clk);
		stall <= 1'b0;
		repeat (30) @(posedge core_clk);
		chk(32'(i_eng.got.size()), 32'h5);
		for (int i = 0; i < 5; i++)
			chk(32'(i_eng.got[i]), 32'(8'ha0 + 8'(i)));
		rdChk(`OFF_TX_SPACE, 32'hff, 32'h40);
		rdChk(`OFF_TX_LATCHED, 32'h02, 32'h02);
		$display("test transmit path done");
		summarize();
	end
endmodule
`default_nettype wire
